// ===== asc_pkg.sv
// Purpose: shared constants for the authentication supervisor
// Assumes: octet-wide segment stream, most significant octet of each field sent first
// Notes:   channel codes, command identifiers and segment lengths
package asc_pkg;
  localparam int          OCT_W         = 8;
  localparam int          CNT_W         = 30;
  localparam int          REC_W         = 8;
  localparam int          REC_ONES_W    = CNT_W - REC_W;
  localparam int          SIG_W         = 40;
  localparam int          KEY_AW        = 9;
  localparam int          TAIL_OCTETS   = 9;
  localparam int          LEN_W         = 9;
  localparam int          PTR_W         = 5;
  localparam int          KEY_BLK_OCT   = 5;
  // channel identifiers
  localparam logic [1:0]  CH_PRINCIPAL  = 2'h0;
  localparam logic [1:0]  CH_AUXILIARY  = 2'h1;
  localparam logic [1:0]  CH_RECOVERY   = 2'h2;
  localparam logic [1:0]  CH_INVALID    = 2'h3;
  // control segment header and access point
  localparam logic [7:0]  HDR_CONTROL   = 8'hFF;
  localparam logic [5:0]  AP_CONTROL    = 6'h3F;
  // command identifiers
  localparam logic [7:0]  CMD_DUMMY     = 8'h00;
  localparam logic [7:0]  CMD_SEL_FIXED = 8'h05;
  localparam logic [7:0]  CMD_SEL_PROG  = 8'h06;
  localparam logic [7:0]  CMD_LOAD_FIX  = 8'h07;
  localparam logic [7:0]  CMD_SET_COUNT = 8'h09;
  localparam logic [7:0]  CMD_BLOCK_A   = 8'h0A;
  localparam logic [7:0]  CMD_BLOCK_B   = 8'h0B;
  // full segment lengths in octets, tail included
  localparam logic [8:0]  LEN_GROUP1    = 9'h00B;
  localparam logic [8:0]  LEN_GROUP2    = 9'h00F;
  localparam logic [8:0]  LEN_GROUP3    = 9'h013;
  localparam logic [8:0]  LEN_MIN       = 9'h00A;
  localparam logic [8:0]  LEN_MAX       = 9'h1FF;
  // octet positions inside a segment
  localparam logic [8:0]  POS_ID        = 9'h001;
  localparam logic [8:0]  POS_DATA_LAST = 9'h009;
  // key memory layout
  localparam logic [8:0]  KEY_B_BASE    = 9'h100;
  localparam logic [7:0]  KEY_B_LIMIT   = 8'h71;
  localparam logic        KEY_FIXED     = 1'b0;
  localparam logic        KEY_PROG      = 1'b1;
  typedef enum logic [1:0] {ST_RECV, ST_WAIT_SIG, ST_WAIT_PSEUDO, ST_WRITE_KEY} asc_state_e;
endpackage

// ===== asc_tail_strip.sv
// Purpose: delay line that holds back the last octets of a segment
// Assumes: flush is pulsed between segments
// Notes:   the octets still held at the end are never emitted
module asc_tail_strip #(
  parameter int DEPTH = asc_pkg::TAIL_OCTETS,
  parameter int WIDTH = asc_pkg::OCT_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  input  wire logic             valid_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic                  valid_out,
  output logic      [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] stage_reg [DEPTH];
  logic [4:0]       fill_reg;
  logic             full;
  assign full = (fill_reg == 5'(DEPTH));

  // one shift stage per held octet
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          stage_reg[g] <= '0;
        end else if (valid_in) begin
          stage_reg[g] <= (g == 0) ? data_in : stage_reg[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // fill level, cleared per segment so no octet leaks across
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fill_reg <= '0;
    end else if (flush_in) begin
      fill_reg <= '0;
    end else if (valid_in && !full) begin
      fill_reg <= fill_reg + 5'h01;
    end
  end

  // the oldest octet leaves only when a newer one pushes it out
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      data_out  <= '0;
    end else begin
      valid_out <= valid_in && full && !flush_in;
      data_out  <= stage_reg[DEPTH-1];
    end
  end

  holdback_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    valid_out |-> $past(full)) else $error("octet emitted before delay line filled");
endmodule

// ===== asc_key_writer.sv
// Purpose: writes a 40-bit pseudo-signature as five key octets
// Assumes: start is ignored while busy
// Notes:   most significant octet goes to the start address
module asc_key_writer
  import asc_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  input  wire logic [KEY_AW-1:0] base_in,
  input  wire logic [SIG_W-1:0]  sig_in,
  output logic                   wr_en_out,
  output logic      [KEY_AW-1:0] wr_addr_out,
  output logic      [OCT_W-1:0]  wr_data_out,
  output logic                   done_out
);
  logic [SIG_W-1:0] sig_reg;
  logic [2:0]       left_reg;

  // shift the signature out one octet per cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sig_reg     <= '0;
      left_reg    <= '0;
      wr_en_out   <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      done_out    <= 1'b0;
    end else begin
      done_out <= (left_reg == 3'h1);
      if (start_in && left_reg == 3'h0) begin
        sig_reg     <= {sig_in[SIG_W-OCT_W-1:0], OCT_W'(0)};
        left_reg    <= 3'(KEY_BLK_OCT - 1);
        wr_en_out   <= 1'b1;
        wr_addr_out <= base_in;
        wr_data_out <= sig_in[SIG_W-1 -: OCT_W];
      end else if (left_reg != 3'h0) begin
        sig_reg     <= {sig_reg[SIG_W-OCT_W-1:0], OCT_W'(0)};
        left_reg    <= left_reg - 3'h1;
        wr_en_out   <= 1'b1;
        wr_addr_out <= wr_addr_out + 9'h001;
        wr_data_out <= sig_reg[SIG_W-1 -: OCT_W];
      end else begin
        wr_en_out <= 1'b0;
      end
    end
  end

  five_octets_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(wr_en_out) |-> wr_en_out [*5] ##1 !wr_en_out) else $error("key block not five octets");
  addr_step_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_en_out && $past(wr_en_out) |-> wr_addr_out == $past(wr_addr_out) + 9'h001)
    else $error("key octet address did not step by one");
endmodule

// ===== asc_supervisor.sv
// Purpose: sequence counters, final authorisation and control commands
// Assumes: upstream streams each segment and later reports the signature match
// Notes:   released octets are provisional until seg_release or seg_discard
module asc_supervisor
  import asc_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic [PTR_W-1:0]  auth_pointer_in,
  input  wire logic              seg_valid_in,
  input  wire logic [OCT_W-1:0]  seg_data_in,
  input  wire logic              seg_last_in,
  input  wire logic              sig_valid_in,
  input  wire logic              sig_match_in,
  input  wire logic              pseudo_valid_in,
  input  wire logic [SIG_W-1:0]  pseudo_sig_in,
  output logic                   out_valid_out,
  output logic      [OCT_W-1:0]  out_data_out,
  output logic                   seg_release_out,
  output logic                   seg_discard_out,
  output logic                   key_sel_out,
  output logic                   key_reload_out,
  output logic                   pseudo_req_out,
  output logic                   key_wr_en_out,
  output logic      [KEY_AW-1:0] key_wr_addr_out,
  output logic      [OCT_W-1:0]  key_wr_data_out,
  output logic                   cmd_done_out,
  output logic                   cmd_reject_out,
  output logic      [OCT_W-1:0]  cmd_id_out,
  output logic      [CNT_W-1:0]  count_principal_out,
  output logic      [CNT_W-1:0]  count_auxiliary_out,
  output logic      [CNT_W-1:0]  count_recovery_out
);
  asc_state_e           state_reg;
  logic [PTR_W-1:0]     ptr_meta_reg;
  logic [PTR_W-1:0]     ptr_reg;
  logic [LEN_W-1:0]     len_reg;
  logic [OCT_W-1:0]     hdr_reg;
  logic [OCT_W-1:0]     id_reg;
  logic [63:0]          data_reg;
  logic [71:0]          tail_reg;
  logic [CNT_W-1:0]     cnt_reg [2];
  logic [REC_W-1:0]     rec_reg;
  logic                 key_reg;
  logic                 key_try_reg;
  logic                 try_reg;
  logic [KEY_AW-1:0]    blk_base_reg;
  logic                 strip_valid;
  logic                 seg_end;
  logic                 flush;
  logic [1:0]           rx_ch;
  logic [CNT_W-1:0]     rx_cnt;
  logic [CNT_W-1:0]     cur_cnt;
  logic                 cnt_eq;
  logic                 is_cmd;
  logic                 in_set;
  logic                 auth_ok;
  logic                 fmt_ok;
  logic                 is_block;
  logic [1:0]           set_ch;
  logic [CNT_W-1:0]     set_cnt;
  logic                 wr_done;
  logic                 verdict;

  assign seg_end = seg_valid_in && seg_last_in && state_reg == ST_RECV;
  assign verdict = sig_valid_in && state_reg == ST_WAIT_SIG;

  // pointer comes from a pin, so it is resynchronised first
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_meta_reg <= '0;
      ptr_reg      <= '0;
    end else begin
      ptr_meta_reg <= auth_pointer_in;
      ptr_reg      <= ptr_meta_reg;
    end
  end

  // received sequence field is the first four tail octets, msb first
  assign rx_ch  = tail_reg[71:70];
  assign rx_cnt = tail_reg[69:40];

  // counter selected by the received channel
  always_comb begin
    cur_cnt = '0;
    if (rx_ch == CH_PRINCIPAL) begin
      cur_cnt = cnt_reg[0];
    end else if (rx_ch == CH_AUXILIARY) begin
      cur_cnt = cnt_reg[1];
    end else if (rx_ch == CH_RECOVERY) begin
      cur_cnt = {{REC_ONES_W{1'b1}}, rec_reg};
    end
  end

  assign cnt_eq  = (rx_ch != CH_INVALID) && (rx_cnt == cur_cnt);
  assign is_cmd  = (hdr_reg[5:0] == AP_CONTROL);
  assign in_set  = (hdr_reg[PTR_W-1:0] <= ptr_reg);
  assign auth_ok = sig_match_in && cnt_eq && (is_cmd || in_set);
  assign is_block = (id_reg == CMD_BLOCK_A) || (id_reg == CMD_BLOCK_B);
  assign set_ch  = data_reg[63:62];
  assign set_cnt = data_reg[61:32];

  // command format check on header, identifier, length and content
  always_comb begin
    fmt_ok = 1'b0;
    if (hdr_reg != HDR_CONTROL) begin
      fmt_ok = 1'b0;
    end else if (id_reg == CMD_DUMMY || id_reg == CMD_SEL_FIXED ||
                 id_reg == CMD_SEL_PROG || id_reg == CMD_LOAD_FIX) begin
      fmt_ok = (len_reg == LEN_GROUP1);
    end else if (id_reg == CMD_SET_COUNT) begin
      fmt_ok = (len_reg == LEN_GROUP2) && (set_ch != CH_INVALID);
    end else if (id_reg == CMD_BLOCK_A) begin
      fmt_ok = (len_reg == LEN_GROUP3);
    end else if (id_reg == CMD_BLOCK_B) begin
      fmt_ok = (len_reg == LEN_GROUP3) && (data_reg[63:56] < KEY_B_LIMIT);
    end
  end

  // segment capture: header, identifier, command data and running tail
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      len_reg  <= '0;
      hdr_reg  <= '0;
      id_reg   <= '0;
      data_reg <= '0;
      tail_reg <= '0;
    end else if (seg_valid_in && state_reg == ST_RECV) begin
      len_reg  <= seg_last_in ? '0 : ((len_reg == LEN_MAX) ? len_reg : len_reg + 9'h001);
      tail_reg <= {tail_reg[63:0], seg_data_in};
      if (len_reg == '0) begin
        hdr_reg <= seg_data_in;
      end else if (len_reg == POS_ID) begin
        id_reg <= seg_data_in;
      end else if (len_reg <= POS_DATA_LAST) begin
        data_reg <= {data_reg[55:0], seg_data_in};
      end
      if (seg_last_in) begin
        len_reg <= (len_reg + 9'h001 < LEN_MIN) ? '0 : len_reg + 9'h001;
      end
    end else if (verdict) begin
      len_reg <= '0;  // next header lands at zero
    end
  end

  // main sequence: receive, await verdict, optional key block rewrite
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_RECV;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (seg_end && len_reg + 9'h001 >= LEN_MIN) begin
            state_reg <= ST_WAIT_SIG;
          end
        end
        ST_WAIT_SIG: begin
          if (verdict && auth_ok && is_cmd && fmt_ok && is_block) begin
            state_reg <= ST_WAIT_PSEUDO;
          end else if (verdict) begin
            state_reg <= ST_RECV;
          end
        end
        ST_WAIT_PSEUDO: begin
          if (pseudo_valid_in) begin
            state_reg <= ST_WRITE_KEY;
          end
        end
        ST_WRITE_KEY: begin
          if (wr_done) begin
            state_reg <= ST_RECV;
          end
        end
        default: state_reg <= ST_RECV;
      endcase
    end
  end

  // delay line is flushed when the segment is released or discarded
  assign flush = seg_release_out || seg_discard_out;

  // tail removal: the last nine octets stay inside the delay line
  asc_tail_strip #(
    .DEPTH (TAIL_OCTETS),
    .WIDTH (OCT_W)
  ) u_strip (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .flush_in    (flush),
    .valid_in    (seg_valid_in && state_reg == ST_RECV),
    .data_in     (seg_data_in),
    .valid_out   (strip_valid),
    .data_out    (out_data_out)
  );
  // control segments never show octets downstream
  assign out_valid_out = strip_valid && !(hdr_reg[5:0] == AP_CONTROL);

  // release or drop of the provisional octets
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seg_release_out <= 1'b0;
      seg_discard_out <= 1'b0;
    end else begin
      seg_release_out <= verdict && auth_ok && !is_cmd;
      seg_discard_out <= (verdict && !(auth_ok && !is_cmd)) ||
                         (seg_end && len_reg + 9'h001 < LEN_MIN);
    end
  end

  // counters: step on any authorisation, set command overrides
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
      rec_reg    <= '0;
    end else if (verdict && auth_ok) begin
      if (rx_ch == CH_PRINCIPAL) begin
        cnt_reg[0] <= cnt_reg[0] + 30'h00000001;
      end else if (rx_ch == CH_AUXILIARY) begin
        cnt_reg[1] <= cnt_reg[1] + 30'h00000001;
      end else if (rx_ch == CH_RECOVERY) begin
        rec_reg <= rec_reg + 8'h01;
      end
      if (is_cmd && fmt_ok && id_reg == CMD_SET_COUNT) begin
        if (set_ch == CH_PRINCIPAL) begin
          cnt_reg[0] <= set_cnt;
        end else if (set_ch == CH_AUXILIARY) begin
          cnt_reg[1] <= set_cnt;
        end else if (set_ch == CH_RECOVERY) begin
          rec_reg <= set_cnt[REC_W-1:0];
        end
      end
    end
  end

  // tentative key for select commands, seen at the identifier octet
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_reg     <= KEY_FIXED;
      key_try_reg <= KEY_FIXED;
      try_reg     <= 1'b0;
    end else begin
      if (seg_valid_in && state_reg == ST_RECV && len_reg == POS_ID &&
          hdr_reg == HDR_CONTROL &&
          (seg_data_in == CMD_SEL_FIXED || seg_data_in == CMD_SEL_PROG)) begin
        try_reg     <= 1'b1;
        key_try_reg <= (seg_data_in == CMD_SEL_PROG) ? KEY_PROG : KEY_FIXED;
      end else if (verdict || seg_discard_out) begin
        try_reg <= 1'b0;  // failure falls back to key_reg
      end
      if (verdict && auth_ok && is_cmd && fmt_ok && try_reg) begin
        key_reg <= key_try_reg;
      end
    end
  end
  // the hashing side sees the tentative key only during that segment
  assign key_sel_out = try_reg ? key_try_reg : key_reg;

  // command execution strobes and telemetry identifier
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_reload_out <= 1'b0;
      pseudo_req_out <= 1'b0;
      cmd_done_out   <= 1'b0;
      cmd_reject_out <= 1'b0;
      cmd_id_out     <= '0;
      blk_base_reg   <= '0;
    end else begin
      key_reload_out <= verdict && auth_ok && is_cmd && fmt_ok && id_reg == CMD_LOAD_FIX;
      pseudo_req_out <= verdict && auth_ok && is_cmd && fmt_ok && is_block;
      cmd_done_out   <= (verdict && auth_ok && is_cmd && fmt_ok && !is_block) ||
                        (state_reg == ST_WRITE_KEY && wr_done);
      cmd_reject_out <= verdict && auth_ok && is_cmd && !fmt_ok;
      if (verdict && auth_ok && is_cmd) begin
        cmd_id_out <= id_reg;
        blk_base_reg <= (id_reg == CMD_BLOCK_B) ? KEY_B_BASE + {1'b0, data_reg[63:56]}
                                                : {1'b0, data_reg[63:56]};
      end
    end
  end

  // pseudo-signature lands in programmable key memory
  asc_key_writer u_writer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .start_in    (state_reg == ST_WAIT_PSEUDO && pseudo_valid_in),
    .base_in     (blk_base_reg),
    .sig_in      (pseudo_sig_in),
    .wr_en_out   (key_wr_en_out),
    .wr_addr_out (key_wr_addr_out),
    .wr_data_out (key_wr_data_out),
    .done_out    (wr_done)
  );

  // telemetry view of the three counters
  assign count_principal_out = cnt_reg[0];
  assign count_auxiliary_out = cnt_reg[1];
  assign count_recovery_out  = {{REC_ONES_W{1'b1}}, rec_reg};

  rec_upper_ones_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    &count_recovery_out[CNT_W-1:REC_W]) else $error("recovery upper bits not ones");
  step_only_ok_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(verdict && auth_ok) |=> $stable(count_principal_out) && $stable(count_auxiliary_out))
    else $error("counter moved without authorisation");
  step_by_one_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    verdict && auth_ok && rx_ch == CH_PRINCIPAL && !(is_cmd && id_reg == CMD_SET_COUNT)
    |=> count_principal_out == $past(count_principal_out) + 30'h00000001)
    else $error("principal counter did not step by one");
  mismatch_drop_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    verdict && sig_match_in && !cnt_eq |=> seg_discard_out && !seg_release_out)
    else $error("count mismatch not rejected");
  ctrl_never_out_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    verdict && is_cmd |=> !seg_release_out) else $error("control segment released");
  bad_cmd_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    verdict && auth_ok && is_cmd && id_reg == CMD_SET_COUNT && set_ch == CH_INVALID
    |=> cmd_reject_out) else $error("set count on channel 11 not refused");
  key_restore_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    verdict && !sig_match_in |=> key_sel_out == $past(key_reg))
    else $error("previous key not restored");
  pseudo_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_reg == ST_WAIT_PSEUDO && pseudo_valid_in |-> ##1 key_wr_en_out && key_wr_addr_out == blk_base_reg)
    else $error("pseudo-signature not written at start address");
endmodule

// ===== asc_auth_model.sv
// Purpose: far-side model, signature processor answering the supervisor
// Assumes: one verdict per segment, one pseudo-signature per request
// Notes:   outside its strobe each data line shows the inverse value
module asc_auth_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        seg_last_in,
  input  wire logic        match_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic [39:0] sig_in,
  output logic             sig_valid_out,
  output logic             sig_match_out,
  output logic             pseudo_valid_out,
  output logic      [39:0] pseudo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  logic [3:0] pwait_reg;
  // verdict after a prompt or a slow hashing time
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) wait_reg <= 4'h0;
    else if (seg_last_in) wait_reg <= slow_in ? 4'h9 : 4'h1;
    else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
  end
  // pseudo-signature rerun, same latency choice
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) pwait_reg <= 4'h0;
    else if (req_in) pwait_reg <= slow_in ? 4'h7 : 4'h1;
    else if (pwait_reg != 4'h0) pwait_reg <= pwait_reg - 4'h1;
  end
  // inverted values keep stale data from passing as valid
  assign sig_valid_out    = (wait_reg == 4'h1);
  assign sig_match_out    = sig_valid_out ? match_in : ~match_in;
  assign pseudo_valid_out = (pwait_reg == 4'h1);
  assign pseudo_out       = pseudo_valid_out ? sig_in : ~sig_in;
endmodule

// ===== auth_supervisor_control_test.sv
// Purpose: self-checking bench for the authentication supervisor
// Assumes: model answers each segment; pointer settles in 2 edges
// Notes:   monitor pops expected octets, events and key writes
module auth_supervisor_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic core_clk_in, rst_in, seg_valid_in, seg_last_in, sig_valid_in, sig_match_in;
  logic pseudo_valid_in, out_valid_out, seg_release_out, seg_discard_out, key_sel_out;
  logic key_reload_out, pseudo_req_out, key_wr_en_out, cmd_done_out, cmd_reject_out;
  logic match_in, slow_in, data_m;
  logic [4:0]  auth_pointer_in;
  logic [7:0]  seg_data_in, out_data_out, key_wr_data_out, cmd_id_out;
  logic [8:0]  key_wr_addr_out;
  logic [39:0] pseudo_sig_in, ps_val;
  logic [29:0] count_principal_out, count_auxiliary_out, count_recovery_out, exp_cnt[3];
  logic [15:0] lf;
  logic [7:0]  q_oct[$];
  logic [16:0] q_key[$];
  logic [1:0]  q_ev[$];
  int          num_errors, check_count;
  asc_supervisor dut_u (.core_clk_in, .rst_in, .auth_pointer_in, .seg_valid_in, .seg_data_in,
    .seg_last_in, .sig_valid_in, .sig_match_in, .pseudo_valid_in, .pseudo_sig_in, .out_valid_out,
    .out_data_out, .seg_release_out, .seg_discard_out, .key_sel_out, .key_reload_out,
    .pseudo_req_out, .key_wr_en_out, .key_wr_addr_out, .key_wr_data_out, .cmd_done_out,
    .cmd_reject_out, .cmd_id_out, .count_principal_out, .count_auxiliary_out, .count_recovery_out);
  asc_auth_model model_u (.core_clk_in, .rst_in, .seg_last_in(seg_valid_in & seg_last_in),
    .match_in, .slow_in, .req_in(pseudo_req_out), .sig_in(ps_val), .sig_valid_out(sig_valid_in),
    .sig_match_out(sig_match_in), .pseudo_valid_out(pseudo_valid_in), .pseudo_out(pseudo_sig_in));
  // free-running clock
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic note(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_oct(input logic [16:0] g, input logic [16:0] e); note({15'h0, g}, {15'h0, e}); endtask
  task automatic cmp_evt(input logic [1:0] g, input logic [1:0] e); note({30'h0, g}, {30'h0, e}); endtask
  task automatic cmp_cnt(input logic [29:0] g, input logic [29:0] e); note({2'h0, g}, {2'h0, e}); endtask
  task automatic complete_run;
    if (q_oct.size() + q_key.size() + q_ev.size() != 0) num_errors++;
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // inputs move on the falling edge, random slowness of the model
  task automatic tick;
    @(negedge core_clk_in);
    lf = lfsr_next(lf);
    slow_in = lf[0];
  endtask
  // one segment: header, body, sequence field, signature; then wait for the verdict
  task automatic run(input logic [7:0] hdr, input int nb, input logic [71:0] body, input logic [1:0] ch,
                     input logic [29:0] cn, input logic ok, input logic [1:0] ev);
    logic [7:0]  oct[$];
    logic [31:0] sq;
    logic        cmd, auth;
    int          n;
    cmd = (hdr[5:0] == AP_CONTROL);
    auth = ok && ch != CH_INVALID && cn === exp_cnt[ch] && (cmd || hdr[4:0] <= auth_pointer_in);
    sq = {ch, cn};
    oct.push_back(hdr);
    for (int i = 0; i < nb; i++) oct.push_back(body[71-8*i -: 8]);
    if (!cmd) begin
      foreach (oct[i]) q_oct.push_back(oct[i]);
      q_ev.push_back(auth ? 2'b10 : 2'b01);
    end
    else if (auth) q_ev.push_back(ev);
    for (int i = 0; i < 4; i++) oct.push_back(sq[31-8*i -: 8]);
    for (int i = 0; i < 5; i++) oct.push_back(lf[7:0] ^ 8'(i));
    data_m = !cmd;
    match_in = ok;
    foreach (oct[i]) begin
      seg_valid_in = 1'b1;
      seg_data_in = oct[i];
      seg_last_in = (i == oct.size() - 1);
      tick;
    end
    seg_valid_in = 1'b0;
    seg_last_in = 1'b0;
    n = 0;
    while (!(seg_release_out | seg_discard_out | cmd_done_out | cmd_reject_out) && n < 60) begin
      tick;
      n++;
    end
    if (cmd && auth) cmp_oct({8'h0, key_reload_out, cmd_id_out},
      {8'h0, nb == 1 && body[71:64] == CMD_LOAD_FIX, body[71:64]});
    while (q_key.size() != 0 && n < 60) begin
      tick;
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      complete_run;
    end
    if (auth) exp_cnt[ch] = (ch == CH_RECOVERY) ? {22'h3FFFFF, cn[7:0] + 8'h01} : cn + 30'h1;
    if (auth && cmd && nb == 5 && body[71:64] == CMD_SET_COUNT && body[63:62] != CH_INVALID)
      exp_cnt[body[63:62]] = (body[63:62] == CH_RECOVERY) ? {22'h3FFFFF, body[39:32]} : body[61:32];
    tick;
    tick;
    cmp_cnt(count_principal_out, exp_cnt[0]);
    cmp_cnt(count_auxiliary_out, exp_cnt[1]);
    cmp_cnt(count_recovery_out, exp_cnt[2]);
  endtask
  // key block command with its five expected key writes when good
  task automatic blk(input logic [7:0] id, input logic [7:0] st, input logic [8:0] base, input logic good);
    ps_val = {lf, lf ^ 16'hA5C3, lf[7:0]};
    if (good) for (int i = 0; i < 5; i++) q_key.push_back({base + 9'(i), ps_val[39-8*i -: 8]});
    run(HDR_CONTROL, 9, {id, st, lf, 40'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, {good, ~good});
  endtask
  // monitor: every result takes the oldest note of its kind
  always @(negedge core_clk_in) begin
    if (!rst_in && out_valid_out) cmp_oct({9'h0, out_data_out}, q_oct.size() ? q_oct.pop_front() : 'x);
    if (!rst_in && data_m && (seg_release_out | seg_discard_out))
      cmp_evt({seg_release_out, seg_discard_out}, q_ev.size() ? q_ev.pop_front() : 'x);
    if (!rst_in && !data_m && (cmd_done_out | cmd_reject_out))
      cmp_evt({cmd_done_out, cmd_reject_out}, q_ev.size() ? q_ev.pop_front() : 'x);
    if (!rst_in && key_wr_en_out) cmp_oct({key_wr_addr_out, key_wr_data_out}, q_key.size() ? q_key.pop_front() : 'x);
  end
  // main sequence
  initial begin
    {rst_in, seg_valid_in, seg_last_in, match_in, slow_in, data_m} = 6'h20;
    {auth_pointer_in, seg_data_in, ps_val} = '0;
    lf = 16'hC3F2;
    exp_cnt = '{30'h0, 30'h0, 30'h3FFFFF00};
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    cmp_cnt(count_recovery_out, exp_cnt[2]);
    cmp_cnt({29'h0, key_sel_out}, 30'h0);
    auth_pointer_in = 5'h01;
    repeat (3) tick;
    run(8'h41, 2, {lf, 56'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b00);
    run(8'h41, 2, {lf, 56'h0}, CH_PRINCIPAL, exp_cnt[0] + 30'h5, 1'b1, 2'b00);
    run(8'h41, 2, {lf, 56'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b0, 2'b00);
    run(8'h42, 2, {lf, 56'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b00);
    run(8'h61, 2, {lf, 56'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b00);
    run(8'h41, 2, {lf, 56'h0}, CH_AUXILIARY, exp_cnt[1], 1'b1, 2'b00);
    run(8'h41, 2, {lf, 56'h0}, CH_RECOVERY, exp_cnt[2], 1'b1, 2'b00);
    run(8'h41, 2, {lf, 56'h0}, CH_INVALID, 30'h0, 1'b1, 2'b00);
    run(HDR_CONTROL, 1, {CMD_DUMMY, 64'h0}, CH_AUXILIARY, exp_cnt[1], 1'b1, 2'b10);
    run(HDR_CONTROL, 1, {CMD_SEL_PROG, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b10);
    cmp_cnt({29'h0, key_sel_out}, 30'h1);
    run(HDR_CONTROL, 1, {CMD_SEL_FIXED, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b0, 2'b00);
    cmp_cnt({29'h0, key_sel_out}, 30'h1);
    run(HDR_CONTROL, 1, {CMD_SEL_FIXED, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b10);
    cmp_cnt({29'h0, key_sel_out}, 30'h0);
    run(HDR_CONTROL, 1, {CMD_LOAD_FIX, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b10);
    run(HDR_CONTROL, 5, {CMD_SET_COUNT, 2'h2, 30'h0ABCDE12, 32'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b10);
    run(HDR_CONTROL, 5, {CMD_SET_COUNT, 2'h1, 30'h01234567, 32'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b10);
    run(HDR_CONTROL, 5, {CMD_SET_COUNT, 2'h3, 30'h00000042, 32'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b01);
    run(HDR_CONTROL, 2, {CMD_DUMMY, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b01);
    run(HDR_CONTROL, 1, {8'h03, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b01);
    run(8'h3F, 1, {CMD_DUMMY, 64'h0}, CH_PRINCIPAL, exp_cnt[0], 1'b1, 2'b01);
    blk(CMD_BLOCK_A, 8'hF0, 9'h0F0, 1'b1);
    blk(CMD_BLOCK_B, 8'h05, 9'h105, 1'b1);
    blk(CMD_BLOCK_B, 8'h71, 9'h000, 1'b0);
    complete_run;
  end
endmodule
